// file: hw/power_mode_pkg.sv
package power_mode_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses on the serial host port)
	// ------------------------------------------------------------
	localparam logic [7:0]  PMC_OFF        = 8'hD4;   // Power management control, 16 bit
	localparam logic [7:0]  CHIP_CFG_OFF   = 8'h08;   // Chip configuration, 16 bit, read only
	localparam logic [15:0] PMC_RESET      = 16'h0000; // Mode field starts at normal
	localparam int          EEPROM_BIT     = 9;       // Strap position in chip configuration
	localparam int          MODE_LSB       = 0;       // Mode field position
	localparam int          MODE_W         = 2;       // Mode field width

	// ------------------------------------------------------------
	// Serial command byte layout
	// ------------------------------------------------------------
	localparam int          CMD_WR_BIT     = 7;       // 1 = write, 0 = read
	localparam int          CMD_SIZE_LSB   = 0;       // Two-bit access size code
	localparam logic [1:0]  SIZE_BYTE      = 2'h0;    // 8-bit access
	localparam logic [1:0]  SIZE_WORD      = 2'h1;    // 16-bit access
	localparam logic [2:0]  BYTES_1        = 3'h1;
	localparam logic [2:0]  BYTES_2        = 3'h2;
	localparam logic [2:0]  BYTES_4        = 3'h4;
	localparam logic [2:0]  BIT_LAST       = 3'h7;    // Last bit index of a byte

	// ------------------------------------------------------------
	// Clocking and reset figures
	// ------------------------------------------------------------
	localparam int          SYS_CLK_MHZ    = 200;     // System clock rate
	localparam int          REF_CLK_MHZ    = 25;      // Reference clock rate
	localparam int          SCLK_MAX_MHZ   = 40;      // Highest serial clock rate
	localparam int          RESET_HOLD_MS  = 10;      // Least external reset hold time
	localparam logic        SO_IDLE        = 1'b1;    // Output level outside data bits

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_ENERGY = 2'h1,
		MODE_UNUSED = 2'h2,
		MODE_SAVING = 2'h3
	} pm_mode_t;

	typedef struct packed {
		logic pll_clk_en;     // Internal PLL clock running
		logic mac_en;         // MAC powered
		logic host_if_en;     // Serial host interface enabled
		logic phy_tx_en;      // PHY transmit section on
		logic phy_rx_full_en; // Full PHY receive section on
		logic rx_energy_det;  // Receive energy detection active
	} block_en_t;

	typedef enum {
		SPI_IDLE,
		SPI_CMD,
		SPI_ADDR,
		SPI_DATA
	} spi_state_t;

endpackage

// file: hw/ethernet_power_mode_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Two-bit mode: 00 normal, 01 energy, 11 saving
// - Reset loads mode field with normal
// - Normal: clocks, PHY, MAC on, host access
// - Host write of mode field changes mode
// - Energy: PLL, MAC, host off; saving: rx trimmed
// - Reset latches EEPROM strap into config bit 9
// - Serial activity only while select low
// - Serial output driven only while selected
// - Serial clock works up to 40 MHz
// - Register access in 8, 16, 32 bits
// - Timing derived from 25 MHz reference
// - Interrupt pin low while any status set
// - Active-low reset holds device in reset
module ethernet_power_mode_control
	import power_mode_pkg::*;
(
	input  wire logic        clk_sys_in,             // System clock
	input  wire logic        rst_b_in,               // Hardware reset, active low
	input  wire logic        ref_clock_in,           // Reference clock pin
	input  wire logic        eeprom_data_strap_in,   // EEPROM data pin at reset
	input  wire logic        chip_select_n_in,       // Serial select, active low
	input  wire logic        sclk_in,                // Serial clock pin
	input  wire logic        si_in,                  // Serial data in
	input  wire logic [15:0] irq_status_in,          // Interrupt status bits
	output logic             so_out,                 // Serial data out
	output logic             so_oe_out,              // Serial data out enable
	output logic             host_irq_n_out,         // Host interrupt, active low
	output logic             ref_tick_out,           // Reference edge pulse for PHY/MAC
	output logic [1:0]       mode_out,               // Effective operating mode
	output block_en_t        block_en_out            // Function block enables
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] cs_sync_q;     // Select synchroniser
	logic [1:0] sclk_sync_q;   // Serial clock synchroniser
	logic [1:0] si_sync_q;     // Serial data synchroniser
	logic [1:0] ref_sync_q;    // Reference clock synchroniser
	logic [1:0] strap_sync_q;  // Strap synchroniser
	logic       cs_n_prev_q;   // Select history for edges
	logic       sclk_prev_q;   // Serial clock history
	logic       ref_prev_q;    // Reference clock history

	// Pins are not reset: the reset cycles flush them to the pin levels,
	// so the edge detectors see no false edge once reset lets go
	// Two stages before logic reads the select, serial clock, serial data, reference or strap pin
	always_ff @(posedge clk_sys_in) begin
		cs_sync_q    <= {cs_sync_q[0], chip_select_n_in};
		sclk_sync_q  <= {sclk_sync_q[0], sclk_in};
		si_sync_q    <= {si_sync_q[0], si_in};
		ref_sync_q   <= {ref_sync_q[0], ref_clock_in};
		strap_sync_q <= {strap_sync_q[0], eeprom_data_strap_in};
		cs_n_prev_q  <= cs_sync_q[1];
		sclk_prev_q  <= sclk_sync_q[1];
		ref_prev_q   <= ref_sync_q[1];
	end

	logic cs_n;       // Synchronised select
	logic cs_fall;    // Select asserted this cycle
	logic sclk_rise;  // Serial clock rising edge
	logic ref_rise;   // Reference rising edge

	assign cs_n      = cs_sync_q[1];
	assign cs_fall   = cs_n_prev_q & ~cs_n;
	assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
	assign ref_rise  = ref_sync_q[1] & ~ref_prev_q;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [15:0] pmc_q, pmc_d;       // Power management control
	logic        strap_q, strap_d;   // Latched EEPROM presence
	logic [1:0]  mode_q;             // Effective mode, mirrors field

	// Mode field with the unassigned code folded onto normal
	function automatic logic [1:0] fold_mode(input logic [1:0] raw);
		fold_mode = (raw == MODE_UNUSED) ? MODE_NORMAL : raw;
	endfunction

	// Unmapped bytes read as zero; the configuration word is read only
	// and carries nothing but the strap bit
	// Byte view of the register map
	function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [15:0] pmc, input logic strap);
		logic [15:0] cfg;
		cfg = 16'h0000;
		cfg[EEPROM_BIT] = strap;
		case (a)
			PMC_OFF:                    read_byte = pmc[7:0];
			PMC_OFF + 8'h01:            read_byte = pmc[15:8];
			CHIP_CFG_OFF:               read_byte = cfg[7:0];
			CHIP_CFG_OFF + 8'h01:       read_byte = cfg[15:8];
			default:                    read_byte = 8'h00;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Serial host port
	// ------------------------------------------------------------
	spi_state_t st_q, st_d;          // Transfer phase
	logic [2:0] bit_q, bit_d;        // Bit index within byte
	logic [7:0] rx_q, rx_d;          // Incoming shift register
	logic [7:0] tx_q, tx_d;          // Outgoing shift register
	logic       is_wr_q, is_wr_d;    // Transfer is a write
	logic [2:0] left_q, left_d;      // Bytes left in the access
	logic [7:0] addr_q, addr_d;      // Current byte address
	logic       so_q, so_d;          // Serial output level
	logic       oe_q, oe_d;          // Serial output enable
	logic       wr_stb;              // Byte write strobe
	logic [7:0] wr_addr;             // Byte write address
	logic [7:0] wr_data;             // Byte write data
	logic       wake_stb;            // Select seen in energy mode
	logic [7:0] rx_byte;             // Byte completed this edge
	logic [7:0] next_tx;             // Next read byte

	// Command, address and data phases
	always_comb begin
		st_d     = st_q;
		bit_d    = bit_q;
		rx_d     = rx_q;
		tx_d     = tx_q;
		is_wr_d  = is_wr_q;
		left_d   = left_q;
		addr_d   = addr_q;
		so_d     = so_q;
		oe_d     = ~cs_n;
		wr_stb   = 1'b0;
		wr_addr  = addr_q;
		wr_data  = 8'h00;
		wake_stb = 1'b0;
		rx_byte  = {rx_q[6:0], si_sync_q[1]};
		next_tx  = read_byte(addr_q, pmc_q, strap_q);
		// A select rise aborts the access at once; partial bytes are dropped
		if (cs_n) begin
			// Deselected: port ignores all activity
			st_d  = SPI_IDLE;
			bit_d = 3'h0;
			so_d  = SO_IDLE;
		end else if (cs_fall) begin
			bit_d = 3'h0;
			so_d  = SO_IDLE;
			if (mode_q == MODE_ENERGY) begin
				// Host interface off; select only wakes the device
				wake_stb = 1'b1;
				st_d     = SPI_IDLE;
			end else begin
				st_d = SPI_CMD;
			end
		end else if (sclk_rise && st_q != SPI_IDLE) begin
			rx_d  = rx_byte;
			bit_d = bit_q + 3'h1;
			tx_d  = {tx_q[6:0], 1'b0};
			so_d  = (st_q == SPI_DATA && !is_wr_q) ? tx_q[6] : SO_IDLE;
			if (bit_q == BIT_LAST) begin
				case (st_q)
					SPI_CMD: begin
						is_wr_d = rx_byte[CMD_WR_BIT];
						case (rx_byte[CMD_SIZE_LSB +: 2])
							SIZE_BYTE: left_d = BYTES_1;
							SIZE_WORD: left_d = BYTES_2;
							default:   left_d = BYTES_4;
						endcase
						st_d = SPI_ADDR;
					end
					SPI_ADDR: begin
						addr_d = rx_byte;
						tx_d   = read_byte(rx_byte, pmc_q, strap_q);
						so_d   = is_wr_q ? SO_IDLE : tx_d[7];
						st_d   = SPI_DATA;
					end
					SPI_DATA: begin
						if (left_q != 3'h0) begin
							// Byte lanes walk upward through the access
							wr_stb = is_wr_q;
							wr_data = rx_byte;
							addr_d = addr_q + 8'h01;
							left_d = left_q - 3'h1;
						end
						tx_d = (left_q > 3'h1) ? read_byte(addr_q + 8'h01, pmc_q, strap_q) : 8'h00;
						so_d = (is_wr_q || left_q <= 3'h1) ? SO_IDLE : tx_d[7];
					end
					default: st_d = SPI_IDLE;
				endcase
			end
		end
	end

	// Serial port registers
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			st_q    <= SPI_IDLE;
			bit_q   <= 3'h0;
			rx_q    <= 8'h00;
			tx_q    <= 8'h00;
			is_wr_q <= 1'b0;
			left_q  <= 3'h0;
			addr_q  <= 8'h00;
			so_q    <= SO_IDLE;
			oe_q    <= 1'b0;
		end else begin
			st_q    <= st_d;
			bit_q   <= bit_d;
			rx_q    <= rx_d;
			tx_q    <= tx_d;
			is_wr_q <= is_wr_d;
			left_q  <= left_d;
			addr_q  <= addr_d;
			so_q    <= so_d;
			oe_q    <= oe_d;
		end
	end

	// ------------------------------------------------------------
	// Mode register and strap
	// ------------------------------------------------------------
	logic [7:0] wr_lo;   // Low byte with folded mode

	// Wake and write never meet: a wake select starts no transfer
	// Register writes and mode transitions
	always_comb begin
		pmc_d   = pmc_q;
		strap_d = strap_q;
		wr_lo   = wr_data;
		wr_lo[MODE_LSB +: MODE_W] = fold_mode(wr_data[MODE_LSB +: MODE_W]);
		if (wake_stb) begin
			pmc_d[MODE_LSB +: MODE_W] = MODE_NORMAL;
		end else if (wr_stb && wr_addr == PMC_OFF) begin
			pmc_d[7:0] = wr_lo;
		end else if (wr_stb && wr_addr == PMC_OFF + 8'h01) begin
			pmc_d[15:8] = wr_data;
		end
	end

	// Strap is taken on every reset cycle; the pin must settle three
	// clock edges before reset is released
	// Reset loads the field; strap follows the pin while in reset
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			pmc_q   <= PMC_RESET;
			strap_q <= strap_sync_q[1];
		end else begin
			pmc_q   <= pmc_d;
			strap_q <= strap_d;
		end
	end

	assign mode_q = fold_mode(pmc_q[MODE_LSB +: MODE_W]);

	// ------------------------------------------------------------
	// Block enables and output flops
	// ------------------------------------------------------------
	block_en_t en_d;        // Next block enables
	logic      tick_d;      // Next reference pulse
	logic      irq_n_d;     // Next interrupt level

	// Enables and the reference pulse leave one flop stage together,
	// so a gated tick never slips past a closing clock gate
	// Mode decode into function block enables
	always_comb begin
		en_d    = '{pll_clk_en: 1'b1, mac_en: 1'b1, host_if_en: 1'b1,
		            phy_tx_en: 1'b1, phy_rx_full_en: 1'b1, rx_energy_det: 1'b1};
		case (mode_q)
			MODE_ENERGY: begin
				en_d.pll_clk_en     = 1'b0;
				en_d.mac_en         = 1'b0;
				en_d.host_if_en     = 1'b0;
				en_d.phy_tx_en      = 1'b0;
				en_d.phy_rx_full_en = 1'b0;
			end
			MODE_SAVING: begin
				en_d.phy_rx_full_en = 1'b0;
			end
			default: begin
				en_d.rx_energy_det  = 1'b1;
			end
		endcase
		tick_d  = ref_rise & en_d.pll_clk_en;
		irq_n_d = ~(|irq_status_in);
	end

	// Output registers
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			block_en_out   <= '{pll_clk_en: 1'b1, mac_en: 1'b1, host_if_en: 1'b1,
			                    phy_tx_en: 1'b1, phy_rx_full_en: 1'b1, rx_energy_det: 1'b1};
			ref_tick_out   <= 1'b0;
			host_irq_n_out <= 1'b1;
			mode_out       <= MODE_NORMAL;
		end else begin
			block_en_out   <= en_d;
			ref_tick_out   <= tick_d;
			host_irq_n_out <= irq_n_d;
			mode_out       <= mode_q;
		end
	end

	assign so_out    = so_q;
	assign so_oe_out = oe_q;

endmodule // ethernet_power_mode_control

// file: test/ethernet_power_mode_control_assertions.sv
`timescale 1ns/1ps
// ------------------------------
// Port checker
// ------------------------------
module ethernet_power_mode_control_assertions
	import power_mode_pkg::*;
(
	input  wire logic        clk_sys_in,       // System clock
	input  wire logic        rst_b_in,         // Reset, active low
	input  wire logic        chip_select_n_in, // Serial select
	input  wire logic [15:0] irq_status_in,    // Status bits
	input  wire logic        so_oe_out,        // Out enable
	input  wire logic        host_irq_n_out,   // Irq pin
	input  wire logic        ref_tick_out,     // Ref pulse
	input  wire logic [1:0]  mode_out,         // Mode
	input  wire block_en_t   block_en_out      // Enables
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	// Select held high
	sequence s_unsel;
		chip_select_n_in [*5];
	endsequence
	// Select falls outside energy mode, then stays low
	sequence s_sel;
		$fell(chip_select_n_in) && mode_out != MODE_ENERGY ##1 !chip_select_n_in [*5];
	endsequence
	// Clock gate closed
	sequence s_pll_off;
		!block_en_out.pll_clk_en [*2];
	endsequence
	chk_irq_set: assert property (|irq_status_in |=> !host_irq_n_out)
		else $error("irq pin not low");
	chk_irq_clear: assert property (irq_status_in == 16'h0000 |=> host_irq_n_out)
		else $error("irq pin not high");
	chk_mode_legal: assert property (mode_out != MODE_UNUSED)
		else $error("mode code 10 seen");
	chk_en_normal: assert property (mode_out == MODE_NORMAL |-> block_en_out == 6'h3F)
		else $error("normal enables wrong");
	chk_en_energy: assert property (mode_out == MODE_ENERGY |-> block_en_out == 6'h01)
		else $error("energy enables wrong");
	chk_en_saving: assert property (mode_out == MODE_SAVING |-> block_en_out == 6'h3D)
		else $error("saving enables wrong");
	chk_oe_idle: assert property (s_unsel |-> !so_oe_out)
		else $error("output driven unselected");
	chk_oe_drive: assert property (s_sel |-> so_oe_out)
		else $error("output not driven");
	chk_tick_gate: assert property (s_pll_off |-> !ref_tick_out)
		else $error("tick with clock gated");
	chk_tick_pulse: assert property (ref_tick_out |=> !ref_tick_out)
		else $error("tick wider than one");
endmodule // ethernet_power_mode_control_assertions

bind ethernet_power_mode_control ethernet_power_mode_control_assertions u_chk (
	.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .chip_select_n_in(chip_select_n_in),
	.irq_status_in(irq_status_in), .so_oe_out(so_oe_out), .host_irq_n_out(host_irq_n_out),
	.ref_tick_out(ref_tick_out), .mode_out(mode_out), .block_en_out(block_en_out));

// file: test/spi_host_model.sv
`timescale 1ns/1ps
// ------------------------------
// Serial host, mode 0, 64 ns clock
// ------------------------------
module spi_host_model (
	output logic      csn_out,  // Select, active low
	output logic      sclk_out, // Serial clock
	output logic      si_out,   // Data to device
	input  wire logic so_in,    // Data from device
	input  wire logic so_oe_in  // Device drives SO
);
	wire so_line = so_oe_in ? so_in : 1'b1; // Pull-up holds SO high
	initial begin
		csn_out = 1'b1;
		sclk_out = 1'b0;
		si_out = 1'b0;
	end
	// One byte, MSB first, sampled at rise
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si_out <= tx[i];
			#32 rx[i] = so_line;
			sclk_out <= 1'b1;
			#32 sclk_out <= 1'b0;
		end
	endtask
	// Whole framed access, data low byte first
	task automatic xfer(input logic wr, input logic [7:0] a, input int n, inout logic [31:0] d);
		logic [7:0] rx;
		csn_out <= 1'b0;
		#64 xbyte({wr, 5'h00, (n == 1) ? 2'h0 : (n == 2) ? 2'h1 : 2'h2}, rx);
		xbyte(a, rx);
		for (int b = 0; b < n; b++) begin
			xbyte(d[8*b+:8], rx);
			d[8*b+:8] = rx;
		end
		#64 csn_out <= 1'b1;
		si_out <= 1'b0; // Pull-down when released
		#200;
	endtask
	// Clock edges with select high
	task automatic stray();
		si_out <= 1'b1;
		repeat (16) #32 sclk_out <= ~sclk_out;
		si_out <= 1'b0;
	endtask
endmodule // spi_host_model

// file: test/ethernet_power_mode_control_tb.sv
`timescale 1ns/1ps
// ------------------------------
// Bench
// ------------------------------
module ethernet_power_mode_control_tb
	import power_mode_pkg::*;
;
	logic        clk_sys, rst_b, ref_clk, strap; // Driven inputs
	logic [15:0] irq_status;                     // Status bits
	wire         chip_select_n, sclk, si, so, so_oe, irq_n, tick;
	wire  [1:0]  mode;
	block_en_t   en;
	int          n_mismatch, samples_checked;
	ethernet_power_mode_control u_dut (.clk_sys_in(clk_sys), .rst_b_in(rst_b), .ref_clock_in(ref_clk),
		.eeprom_data_strap_in(strap), .chip_select_n_in(chip_select_n), .sclk_in(sclk), .si_in(si),
		.irq_status_in(irq_status), .so_out(so), .so_oe_out(so_oe), .host_irq_n_out(irq_n),
		.ref_tick_out(tick), .mode_out(mode), .block_en_out(en));
	spi_host_model u_host (.csn_out(chip_select_n), .sclk_out(sclk), .si_out(si), .so_in(so), .so_oe_in(so_oe));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk; // 25 MHz reference
	end
	// Compare away from clock edges
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		@(negedge clk_sys);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic do_reset(input logic s);
		@(posedge clk_sys);
		strap <= s;
		rst_b <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input int n, input logic [31:0] d);
		logic [31:0] x;
		x = d;
		u_host.xfer(1'b1, a, n, x);
	endtask
	task automatic rd(input logic [7:0] a, input int n, input logic [31:0] e);
		logic [31:0] x;
		x = 32'h00000000;
		u_host.xfer(1'b0, a, n, x);
		chk(x, e);
	endtask
	// Ticks seen in 80 cycles, ten reference periods
	task automatic ticks(input int e);
		int c;
		c = 0;
		repeat (80) begin
			@(posedge clk_sys);
			#1 if (tick === 1'b1) c++;
		end
		chk(c, e);
	endtask
	function automatic logic [5:0] en_for(input logic [1:0] m);
		case (m)
			2'h1: return 6'h01;
			2'h3: return 6'h3D;
			default: return 6'h3F;
		endcase
	endfunction
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		logic [1:0]  m, e;
		logic [31:0] x;
		rst_b = 1'b0;
		strap = 1'b0;
		irq_status = 16'h0000;
		do_reset(1'b1);
		chk(mode, MODE_NORMAL);
		chk({26'h0, en}, 32'h3F);
		chk(so_oe, 1'b0);
		rd(8'h09, 1, 32'h02);
		ticks(10);
		@(posedge clk_sys) irq_status <= 16'h8000;
		repeat (2) @(negedge clk_sys);
		chk(irq_n, 1'b0);
		@(posedge clk_sys) irq_status <= 16'h0000;
		repeat (2) @(negedge clk_sys);
		chk(irq_n, 1'b1);
		for (int i = 3; i >= 0; i--) begin
			m = 2'(i);
			e = (m == MODE_UNUSED) ? MODE_NORMAL : m;
			wr(PMC_OFF, 1, {30'h0, m});
			chk(mode, e);
			chk({26'h0, en}, en_for(e));
			if (e == MODE_ENERGY) begin
				ticks(0);
				x = 32'h00000000;
				u_host.xfer(1'b0, PMC_OFF, 1, x);
				chk(mode, MODE_NORMAL);
			end else rd(PMC_OFF, 1, {30'h0, e});
		end
		wr(PMC_OFF, 2, 32'h0000A503);
		rd(PMC_OFF, 4, 32'h0000A503);
		rd(PMC_OFF + 8'h01, 1, 32'hA5);
		rd(8'h40, 2, 32'h0);
		u_host.stray();
		chk(mode, MODE_SAVING);
		chk(so_oe, 1'b0);
		rd(PMC_OFF, 1, 32'h03);
		do_reset(1'b0);
		chk(mode, MODE_NORMAL);
		rd(8'h09, 1, 32'h00);
		rd(PMC_OFF, 2, 32'h0);
		report_and_stop();
	end
	initial begin
		#200000;
		n_mismatch++;
		report_and_stop();
	end
endmodule // ethernet_power_mode_control_tb
